// ==== rtl/wdt_map.svh ====
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------
// Prescaler ratios
// ----------------------------------------
`define WDT_DIV_SLOW 16384
`define WDT_DIV_FAST 256
`define WDT_PSC_W 14

// ----------------------------------------
// Counter and reset defaults
// ----------------------------------------
`define WDT_CNT_W 16
`define WDT_CNT_MAX 16'hFFFF
`define WDT_DEF_RELOAD 16'hFF00
`define WDT_DEF_SEL_FAST 1'b1

// ----------------------------------------
// Reference timing of the default interval
// ----------------------------------------
`define WDT_REF_INTERVAL_NS 6500000
`define WDT_REF_CLK_MHZ 10
`define WDT_CLK_PERIOD_NS 20
`define WDT_NS_PER_US 1000
`define WDT_REF_TOL_NS 100000

// ----------------------------------------
// Prewarning to reset request delay
// ----------------------------------------
`define WDT_PREWARN_CYCLES 16

`endif

// ==== rtl/wdt_pkg.sv ====
package wdt_pkg;
   typedef logic [15:0] wdt_count_t;
   typedef enum logic [1:0] {
      WDT_RUN = 2'b00,
      WDT_PREWARN = 2'b01,
      WDT_RESREQ = 2'b10
   } wdt_state_e;
endpackage

// ==== rtl/wdt_prescaler.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"

module wdt_prescaler #(
   parameter int DIV_SLOW = `WDT_DIV_SLOW,
   parameter int DIV_FAST = `WDT_DIV_FAST
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic sel_fast_i,
   output var logic tick_o
);
   logic [`WDT_PSC_W-1:0] psc_r;
   logic [`WDT_PSC_W-1:0] last;

   initial begin
      if (DIV_FAST < 2 || DIV_SLOW < DIV_FAST || DIV_SLOW > (1 << `WDT_PSC_W))
         $error("wdt_prescaler: unsupported division ratios");
   end

   assign last = sel_fast_i ? `WDT_PSC_W'(DIV_FAST - 1) : `WDT_PSC_W'(DIV_SLOW - 1);
   assign tick_o = run_i && !clear_i && (psc_r >= last);

   // Clear restarts a full period
   always_ff @(posedge mclk_i) begin
      if (reset_i || clear_i || tick_o) begin
         psc_r <= '0;
      end else if (run_i) begin
         psc_r <= psc_r + `WDT_PSC_W'(1);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/wdt_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"

module wdt_top #(
   parameter int DIV_SLOW = `WDT_DIV_SLOW,
   parameter int DIV_FAST = `WDT_DIV_FAST,
   parameter int PREWARN_CYCLES = `WDT_PREWARN_CYCLES
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic watchdog_enable_cmd_i,
   input wire logic watchdog_disable_cmd_i,
   input wire logic service_i,
   input wire logic cfg_wr_i,
   input wire wdt_pkg::wdt_count_t watchdog_reload_value_i,
   input wire logic cfg_sel_fast_i,
   output var logic enabled_o,
   output var wdt_pkg::wdt_count_t count_o,
   output var logic prewarn_irq_o,
   output var logic reset_req_o
);
   import wdt_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic enabled_r;
   wdt_count_t cnt_r;
   wdt_count_t reload_r;
   logic sel_fast_r;
   wdt_state_e state_r;
   logic [15:0] pw_cnt_r;
   logic tick;
   logic running;
   logic overflow;
   logic pw_done;

   initial begin
      if (PREWARN_CYCLES < 1 || PREWARN_CYCLES > 65535)
         $error("wdt_top: PREWARN_CYCLES out of range");
      // Reset defaults must land on the reference interval
      if ((`WDT_DIV_FAST * (32'h0001_0000 - `WDT_DEF_RELOAD)
            * (`WDT_NS_PER_US / `WDT_REF_CLK_MHZ)) / `WDT_REF_TOL_NS
            != `WDT_REF_INTERVAL_NS / `WDT_REF_TOL_NS)
         $error("wdt_top: default interval off the reference");
   end

   assign running = enabled_r && (state_r == WDT_RUN);
   assign overflow = running && tick && !service_i && (cnt_r == `WDT_CNT_MAX);
   assign pw_done = (pw_cnt_r == 16'(PREWARN_CYCLES - 1));

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   wdt_prescaler #(
      .DIV_SLOW(DIV_SLOW),
      .DIV_FAST(DIV_FAST)
   ) u_psc (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .clear_i(service_i),
      .run_i(running),
      .sel_fast_i(sel_fast_r),
      .tick_o(tick)
   );

   // ----------------------------------------
   // Enable control
   // ----------------------------------------
   // Disable wins if both commands arrive together
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         enabled_r <= 1'b1;
      end else if (watchdog_disable_cmd_i) begin
         enabled_r <= 1'b0;
      end else if (watchdog_enable_cmd_i) begin
         enabled_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Configuration
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         reload_r <= `WDT_DEF_RELOAD;
         sel_fast_r <= `WDT_DEF_SEL_FAST;
      end else if (cfg_wr_i) begin
         reload_r <= watchdog_reload_value_i;
         sel_fast_r <= cfg_sel_fast_i;
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // Service wins over a same-cycle tick, so a late service still saves the system
   // Wraps to zero on overflow, then parks while the failure response runs
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cnt_r <= `WDT_DEF_RELOAD;
      end else if (service_i && state_r == WDT_RUN) begin
         cnt_r <= reload_r;
      end else if (running && tick) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------
   // Failure response
   // ----------------------------------------
   // Once the prewarning is up the reset request follows regardless of service
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_r <= WDT_RUN;
      end else begin
         case (state_r)
            WDT_RUN: begin
               if (overflow) begin
                  state_r <= WDT_PREWARN;
               end
            end
            WDT_PREWARN: begin
               if (pw_done) begin
                  state_r <= WDT_RESREQ;
               end
            end
            WDT_RESREQ: begin
               state_r <= WDT_RESREQ;
            end
            default: begin
               state_r <= WDT_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i || state_r != WDT_PREWARN) begin
         pw_cnt_r <= 16'h0000;
      end else if (!pw_done) begin
         pw_cnt_r <= pw_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         prewarn_irq_o <= 1'b0;
         reset_req_o <= 1'b0;
      end else begin
         prewarn_irq_o <= overflow || (state_r != WDT_RUN);
         reset_req_o <= (state_r == WDT_PREWARN && pw_done) || (state_r == WDT_RESREQ);
      end
   end

   assign enabled_o = enabled_r;
   assign count_o = cnt_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_reset_enabled: assert property (@(posedge mclk_i) disable iff (reset_i)
      $past(reset_i) |-> enabled_r && cnt_r == `WDT_DEF_RELOAD)
      else $error("watchdog not enabled after reset");

   a_disable_stops: assert property (@(posedge mclk_i) disable iff (reset_i)
      watchdog_disable_cmd_i |=> !enabled_r)
      else $error("disable command ignored");

   a_disabled_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!enabled_r && !service_i) |=> $stable(cnt_r))
      else $error("counter moved while disabled");

   a_enable_resumes: assert property (@(posedge mclk_i) disable iff (reset_i)
      (watchdog_enable_cmd_i && !watchdog_disable_cmd_i) |=> enabled_r)
      else $error("enable command ignored");

   a_overflow_order: assert property (@(posedge mclk_i) disable iff (reset_i)
      overflow |=> prewarn_irq_o && !reset_req_o)
      else $error("prewarning missing after overflow");

   a_reset_after_pw: assert property (@(posedge mclk_i) disable iff (reset_i)
      $rose(reset_req_o) |-> $past(prewarn_irq_o) && prewarn_irq_o)
      else $error("reset request without prior prewarning");

   a_irq_sticky: assert property (@(posedge mclk_i) disable iff (reset_i)
      prewarn_irq_o |=> prewarn_irq_o)
      else $error("prewarning dropped before reset");

   a_resreq_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
      reset_req_o |=> reset_req_o)
      else $error("reset request dropped before reset");

   a_count_step: assert property (@(posedge mclk_i) disable iff (reset_i)
      (running && tick && !service_i && cnt_r != `WDT_CNT_MAX) |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not step on tick");

   a_service_reload: assert property (@(posedge mclk_i) disable iff (reset_i)
      (service_i && state_r == WDT_RUN) |=> cnt_r == $past(reload_r))
      else $error("service did not load reload value");

   a_service_psc: assert property (@(posedge mclk_i) disable iff (reset_i)
      service_i |-> !tick ##1 !tick)
      else $error("prescaler not cleared by service");

   a_default_cfg: assert property (@(posedge mclk_i) disable iff (reset_i)
      $past(reset_i) |-> reload_r == `WDT_DEF_RELOAD && sel_fast_r == `WDT_DEF_SEL_FAST)
      else $error("wrong default configuration");

   c_overflow: cover property (@(posedge mclk_i) disable iff (reset_i) overflow);
   c_reset_req: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(reset_req_o));
   c_service: cover property (@(posedge mclk_i) disable iff (reset_i) service_i && running);
   c_disabled: cover property (@(posedge mclk_i) disable iff (reset_i) !enabled_r ##1 enabled_r);
   c_late_service: cover property (@(posedge mclk_i) disable iff (reset_i) service_i && !running);
endmodule
`default_nettype wire

// ==== verification/watchdog_timer_test.sv ====
`timescale 1ns/1ns
`default_nettype none

module watchdog_timer_test;
   import wdt_pkg::*;
   // ----------------------------------------
   // Shortened counts keep the run brief
   // ----------------------------------------
   localparam int DIV_F = 4;
   localparam int DIV_S = 8;
   localparam int PW = 2;
   logic mclk_i, reset_i, en_cmd, dis_cmd, service_i, cfg_wr_i, sel_fast;
   wdt_count_t reload_v, count_o;
   logic enabled_o, prewarn_irq_o, reset_req_o;
   int miscompares = 0;
   int n_compared = 0;
   int n;

   wdt_top #(.DIV_SLOW(DIV_S), .DIV_FAST(DIV_F), .PREWARN_CYCLES(PW)) uut (
      .mclk_i(mclk_i), .reset_i(reset_i), .watchdog_enable_cmd_i(en_cmd),
      .watchdog_disable_cmd_i(dis_cmd), .service_i(service_i), .cfg_wr_i(cfg_wr_i),
      .watchdog_reload_value_i(reload_v), .cfg_sel_fast_i(sel_fast), .enabled_o(enabled_o),
      .count_o(count_o), .prewarn_irq_o(prewarn_irq_o), .reset_req_o(reset_req_o));

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task strobe(input logic svc, input logic en, input logic dis);
      @(posedge mclk_i);
      service_i <= svc;
      en_cmd <= en;
      dis_cmd <= dis;
      @(posedge mclk_i);
      service_i <= 1'b0;
      en_cmd <= 1'b0;
      dis_cmd <= 1'b0;
      #1;
   endtask

   task cfg(input wdt_count_t v, input logic fast);
      @(posedge mclk_i);
      reload_v <= v;
      sel_fast <= fast;
      cfg_wr_i <= 1'b1;
      @(posedge mclk_i);
      cfg_wr_i <= 1'b0;
      #1;
   endtask

   // Cycles until the count moves, capped so a stuck counter cannot hang
   task wait_change();
      logic [15:0] c;
      c = count_o;
      n = 0;
      while (count_o === c && n < 40) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
   endtask

   function logic [15:0] near(input int got, input int want);
      return {15'h0000, (got >= want - 1 && got <= want + 1)};
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset();
      check("enabled", {15'h0000, enabled_o}, 16'h0001);
      check("count", count_o, 16'hFF00);
      check("flags", {14'h0000, prewarn_irq_o, reset_req_o}, 16'h0000);
      wait_change();
      check("first tick", {15'h0000, n <= DIV_F + 1}, 16'h0001);
      check("count up", count_o, 16'hFF01);
      $display("reset test done");
   endtask

   task t_reload();
      cfg(16'hFFF0, 1'b1);
      strobe(1'b1, 1'b0, 1'b0);
      check("reload", count_o, 16'hFFF0);
      wait_change();
      check("fast period", near(n, DIV_F), 16'h0001);
      check("after tick", count_o, 16'hFFF1);
      cfg(16'hFFF0, 1'b0);
      strobe(1'b1, 1'b0, 1'b0);
      repeat (DIV_S - 3) @(posedge mclk_i);
      strobe(1'b1, 1'b0, 1'b0);
      wait_change();
      check("slow full period", near(n, DIV_S), 16'h0001);
      $display("reload test done");
   endtask

   task t_disable();
      logic [15:0] c;
      strobe(1'b0, 1'b0, 1'b1);
      check("disabled", {15'h0000, enabled_o}, 16'h0000);
      c = count_o;
      repeat (3 * DIV_S) @(posedge mclk_i);
      #1;
      check("held", count_o, c);
      strobe(1'b1, 1'b0, 1'b0);
      check("reload off", count_o, 16'hFFF0);
      strobe(1'b0, 1'b1, 1'b0);
      check("enabled", {15'h0000, enabled_o}, 16'h0001);
      wait_change();
      check("resumed", count_o, 16'hFFF1);
      strobe(1'b0, 1'b1, 1'b1);
      check("both cmds", {15'h0000, enabled_o}, 16'h0000);
      strobe(1'b0, 1'b1, 1'b0);
      $display("disable test done");
   endtask

   task t_overflow();
      cfg(16'hFFFE, 1'b1);
      strobe(1'b1, 1'b0, 1'b0);
      n = 0;
      while (prewarn_irq_o !== 1'b1 && n < 40) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      check("overflow time", near(n, 2 * DIV_F + 1), 16'h0001);
      check("order", {14'h0000, prewarn_irq_o, reset_req_o}, 16'h0002);
      check("wrapped", count_o, 16'h0000);
      n = 0;
      while (reset_req_o !== 1'b1 && n < 40) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      check("reset delay", n[15:0], 16'(PW));
      strobe(1'b1, 1'b0, 1'b0);
      check("no cancel", {14'h0000, prewarn_irq_o, reset_req_o}, 16'h0003);
      @(posedge mclk_i);
      reset_i <= 1'b1;
      @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check("re-armed", {13'h0000, enabled_o, prewarn_irq_o, reset_req_o}, 16'h0004);
      check("re-count", count_o, 16'hFF00);
      $display("overflow test done");
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task final_report();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole sequence needs well under 1000 cycles
   initial begin
      #200000;
      miscompares++;
      final_report();
   end

   initial begin
      reset_i = 1'b1;
      en_cmd = 1'b0;
      dis_cmd = 1'b0;
      service_i = 1'b0;
      cfg_wr_i = 1'b0;
      sel_fast = 1'b1;
      reload_v = 16'h0000;
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      t_reset();
      t_reload();
      t_disable();
      t_overflow();
      final_report();
   end
endmodule

`default_nettype wire
